//--- common/dgo_params.svh
`ifndef DGO_PARAMS_SVH
`define DGO_PARAMS_SVH

// ==========================================================
// register indices on the register port
`define DGO_IDX_DATA        2'h0
`define DGO_IDX_GAIN        2'h1
`define DGO_IDX_OFFSET      2'h2
`define DGO_IDX_STATUS      2'h3

// ==========================================================
// reset values
`define DGO_RST_DATA        16'h0000
`define DGO_RST_GAIN        16'h8000
`define DGO_RST_OFFSET      16'h0000

// ==========================================================
// status register fields
`define DGO_STAT_BUSY       0
`define DGO_STAT_CLAMP_HI   1
`define DGO_STAT_CLAMP_LO   2
`define DGO_STAT_VALID      3

// ==========================================================
// output span in microvolts (2.5 V)
`define DGO_FSR_UV          22'h2625A0
`define DGO_FSR_UV_W        22

`endif

//--- common/dgo_pkg.sv
package dgo_pkg;

	// ==========================================================
	// types
	typedef logic [1:0] dgo_reg_idx_t;

	typedef enum logic [2:0]
	{
		DGO_IDLE = 3'b001,
		DGO_MULT = 3'b010,
		DGO_SUM  = 3'b100
	} dgo_state_t;

endpackage : dgo_pkg

//--- hdl/dgo_calibration.sv
`timescale 1ns/10ps
`default_nettype none
`include "dgo_params.svh"

//
// Contract
// - The converter code is the input word times the gain factor plus the signed offset, in LSBs.
// - The gain trim means one half plus the code over two to the resolution, 0x8000 being unity.
// - The offset trim is a two's-complement number from 0x8000 up to 0x7FFF.
// - The code width is 16 or 14 bits and valid codes run from zero to two to that width minus one.
// - Input, gain and offset sit left justified in 16 bits and the 14-bit build drops the two LSBs.
// - The gain product is truncated, never rounded.
// - New trims take effect only when the input word is next written.
// - The output level is the code over two to the resolution times the 2.5 V span.
module dgo_calibration #(
	parameter int RES = 16
) (
	input  wire logic                      clk,                 // system clock
	input  wire logic                      rst,                 // async reset, high
	input  wire logic                      reg_wr,              // register write strobe
	input  wire logic                      reg_rd,              // register read strobe
	input  wire dgo_pkg::dgo_reg_idx_t     reg_idx,             // register index
	input  wire logic [15:0]               reg_wdata,           // write data
	output logic [15:0]                    reg_rdata,           // read data
	output logic                           reg_rvalid,          // read data valid pulse
	output logic [RES-1:0]                 conv_code,           // code to converter
	output logic                           code_load,           // new code pulse
	output logic                           busy,                // calibration running
	output logic [`DGO_FSR_UV_W-1:0]       analog_output_level  // output in microvolts
);
	import dgo_pkg::*;

	// ==========================================================
	// left-justified field extraction
	function automatic logic [RES-1:0] justify(input logic [15:0] v);
		return v[15 -: RES];
	endfunction : justify

	// ==========================================================
	// register file
	logic [15:0] input_word_r;
	logic [15:0] input_word_nxt;
	logic [15:0] slope_trim_r;
	logic [15:0] slope_trim_nxt;
	logic [15:0] zero_shift_r;
	logic [15:0] zero_shift_nxt;
	logic [15:0] reg_rdata_nxt;
	logic        reg_rvalid_nxt;
	logic        data_wr;
	logic [15:0] status_word;

	assign data_wr = reg_wr && (reg_idx == `DGO_IDX_DATA);

	always_comb
	begin
		input_word_nxt = input_word_r;
		slope_trim_nxt = slope_trim_r;
		zero_shift_nxt = zero_shift_r;
		if (reg_wr)
		begin
			unique case (reg_idx)
				`DGO_IDX_DATA:   input_word_nxt = reg_wdata;
				`DGO_IDX_GAIN:   slope_trim_nxt = reg_wdata;
				`DGO_IDX_OFFSET: zero_shift_nxt = reg_wdata;
				`DGO_IDX_STATUS: input_word_nxt = input_word_r;
			endcase
		end
		reg_rvalid_nxt = reg_rd;
		reg_rdata_nxt  = reg_rdata;
		if (reg_rd)
		begin
			unique case (reg_idx)
				`DGO_IDX_DATA:   reg_rdata_nxt = input_word_r;
				`DGO_IDX_GAIN:   reg_rdata_nxt = slope_trim_r;
				`DGO_IDX_OFFSET: reg_rdata_nxt = zero_shift_r;
				`DGO_IDX_STATUS: reg_rdata_nxt = status_word;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			input_word_r <= `DGO_RST_DATA;
			slope_trim_r <= `DGO_RST_GAIN;
			zero_shift_r <= `DGO_RST_OFFSET;
			reg_rdata    <= 16'h0000;
			reg_rvalid   <= 1'b0;
		end
		else
		begin
			input_word_r <= input_word_nxt;
			slope_trim_r <= slope_trim_nxt;
			zero_shift_r <= zero_shift_nxt;
			reg_rdata    <= reg_rdata_nxt;
			reg_rvalid   <= reg_rvalid_nxt;
		end
	end

	// ==========================================================
	// multiply stage
	logic           mult_done;
	logic [RES:0]   product;

	dgo_slope_mult #(
		.RES       (RES)
	) u_mult (
		.clk       (clk),
		.rst       (rst),
		.start     (data_wr),
		.data_in   (justify(reg_wdata)),
		.gain_in   (justify(slope_trim_r)),
		.done_r    (mult_done),
		.product_r (product)
	);

	// ==========================================================
	// sequencing, offset add, clamp
	dgo_state_t             state_r;
	dgo_state_t             state_nxt;
	logic [RES-1:0]         shift_snap_r;
	logic [RES-1:0]         shift_snap_nxt;
	logic [RES-1:0]         conv_code_nxt;
	logic                   code_load_nxt;
	logic                   clamp_hi_r;
	logic                   clamp_hi_nxt;
	logic                   clamp_lo_r;
	logic                   clamp_lo_nxt;
	logic                   loaded_r;
	logic                   loaded_nxt;
	logic signed [RES+1:0]  sum;
	logic [RES+`DGO_FSR_UV_W-1:0] level_full;
	logic [`DGO_FSR_UV_W-1:0]     level_nxt;

	always_comb
	begin
		state_nxt      = state_r;
		shift_snap_nxt = shift_snap_r;
		conv_code_nxt  = conv_code;
		code_load_nxt  = 1'b0;
		clamp_hi_nxt   = clamp_hi_r;
		clamp_lo_nxt   = clamp_lo_r;
		loaded_nxt     = loaded_r;
		sum            = $signed({1'b0, product})
		               + $signed({{2{shift_snap_r[RES-1]}}, shift_snap_r});
		unique case (state_r)
			DGO_IDLE:
			begin
				state_nxt = DGO_IDLE;
			end
			DGO_MULT:
			begin
				if (mult_done)
				begin
					state_nxt = DGO_SUM;
				end
			end
			DGO_SUM:
			begin
				state_nxt     = DGO_IDLE;
				code_load_nxt = 1'b1;
				loaded_nxt    = 1'b1;
				clamp_hi_nxt  = 1'b0;
				clamp_lo_nxt  = 1'b0;
				if (sum < 0)
				begin
					conv_code_nxt = '0;
					clamp_lo_nxt  = 1'b1;
				end
				else if (sum[RES])
				begin
					conv_code_nxt = '1;
					clamp_hi_nxt  = 1'b1;
				end
				else
				begin
					conv_code_nxt = sum[RES-1:0];
				end
			end
		endcase
		// a data write restarts the pipeline with the trims of that moment
		// and drops a result that was about to load
		if (data_wr)
		begin
			state_nxt      = DGO_MULT;
			shift_snap_nxt = justify(zero_shift_r);
			code_load_nxt  = 1'b0;
			conv_code_nxt  = conv_code;
			clamp_hi_nxt   = clamp_hi_r;
			clamp_lo_nxt   = clamp_lo_r;
			loaded_nxt     = loaded_r;
		end
		level_full = (RES+`DGO_FSR_UV_W)'(conv_code_nxt)
		           * (RES+`DGO_FSR_UV_W)'(`DGO_FSR_UV);
		level_nxt  = level_full[RES+`DGO_FSR_UV_W-1:RES];
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_r             <= DGO_IDLE;
			shift_snap_r        <= '0;
			conv_code           <= '0;
			code_load           <= 1'b0;
			clamp_hi_r          <= 1'b0;
			clamp_lo_r          <= 1'b0;
			loaded_r            <= 1'b0;
			busy                <= 1'b0;
			analog_output_level <= '0;
		end
		else
		begin
			state_r             <= state_nxt;
			shift_snap_r        <= shift_snap_nxt;
			conv_code           <= conv_code_nxt;
			code_load           <= code_load_nxt;
			clamp_hi_r          <= clamp_hi_nxt;
			clamp_lo_r          <= clamp_lo_nxt;
			loaded_r            <= loaded_nxt;
			busy                <= (state_nxt != DGO_IDLE);
			analog_output_level <= level_nxt;
		end
	end

	// ==========================================================
	// status word
	always_comb
	begin
		status_word                     = 16'h0000;
		status_word[`DGO_STAT_BUSY]     = busy;
		status_word[`DGO_STAT_CLAMP_HI] = clamp_hi_r;
		status_word[`DGO_STAT_CLAMP_LO] = clamp_lo_r;
		status_word[`DGO_STAT_VALID]    = loaded_r;
	end

endmodule : dgo_calibration

`default_nettype wire

//--- hdl/dgo_slope_mult.sv
`timescale 1ns/10ps
`default_nettype none

module dgo_slope_mult #(
	parameter int RES = 16
) (
	input  wire logic           clk,       // system clock
	input  wire logic           rst,       // async reset, high
	input  wire logic           start,     // begin one multiply
	input  wire logic [RES-1:0] data_in,   // justified input word
	input  wire logic [RES-1:0] gain_in,   // justified gain trim
	output logic                done_r,    // product ready pulse
	output logic [RES:0]        product_r  // truncated product
);

	// ==========================================================
	// gain factor = 1/2 + gain/2^RES, scaled by 2^RES
	logic [RES:0]     factor;
	logic [2*RES:0]   full;
	logic             done_nxt;
	logic [RES:0]     product_nxt;

	always_comb
	begin
		factor      = (RES+1)'(1 << (RES-1)) + {1'b0, gain_in};
		full        = (2*RES+1)'(data_in) * (2*RES+1)'(factor);
		done_nxt    = start;
		product_nxt = product_r;
		if (start)
		begin
			product_nxt = full[2*RES:RES];
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			done_r    <= 1'b0;
			product_r <= '0;
		end
		else
		begin
			done_r    <= done_nxt;
			product_r <= product_nxt;
		end
	end

endmodule : dgo_slope_mult

`default_nettype wire

//--- tb/dgo_calibration_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "dgo_params.svh"

module dgo_calibration_bench;
	import dgo_pkg::*;
	logic               clk, rst, reg_wr, reg_rd, reg_rvalid, code_load, busy, hi, lo;
	dgo_reg_idx_t       reg_idx;
	logic [15:0]        reg_wdata, reg_rdata, conv_code, exp_c, lf, rd_d, rd_g;
	logic [21:0]        analog_output_level;
	logic [47:0]        tbl [6];
	int                 error_cnt, comparisons, cyc;

	dgo_calibration #(.RES(16)) dgo_calibration_inst (.clk(clk), .rst(rst), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .conv_code(conv_code), .code_load(code_load), .busy(busy),
		.analog_output_level(analog_output_level));

	// ==========================================================
	// helpers
	function automatic logic [15:0] nx(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : nx

	function automatic logic [15:0] ecode(input logic [15:0] d, g, o, output logic h, l);
		logic [33:0]        p;
		logic signed [18:0] s;
		p = 34'(d) * (34'h8000 + 34'(g));
		s = $signed({2'b00, p[32:16]}) + 19'($signed(o));
		l = s < 0;
		h = s > 19'sd65535;
		return l ? 16'h0000 : (h ? 16'hFFFF : s[15:0]);
	endfunction : ecode

	task automatic final_report();
		if (error_cnt == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ev);
		comparisons++;
		if (seen !== ev)
		begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", nm, ev, seen);
		end
	endtask : chk

	task automatic wr(input dgo_reg_idx_t i, input logic [15:0] d);
		reg_wr = 1'b1;
		reg_idx = i;
		reg_wdata = d;
		@(posedge clk);
		#1;
	endtask : wr

	task automatic rd(input dgo_reg_idx_t i, input logic [15:0] e);
		reg_rd = 1'b1;
		reg_idx = i;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		chk("rvalid", reg_rvalid, 1'b1);
		chk("rdata", reg_rdata, e);
		@(posedge clk);
		#1;
	endtask : rd

	task automatic cal(input logic [15:0] d, g, o, input logic rs);
		logic [63:0] lv;
		wr(`DGO_IDX_GAIN, g);
		wr(`DGO_IDX_OFFSET, o);
		if (rs)
			wr(`DGO_IDX_DATA, ~d);
		wr(`DGO_IDX_DATA, d);
		reg_wr = 1'b0;
		exp_c = ecode(d, g, o, hi, lo);
		lv = (64'(exp_c) * 64'd2500000) >> 16;
		chk("busy", busy, 1'b1);
		repeat (2) @(posedge clk);
		#1;
		chk("load", code_load, 1'b1);
		chk("code", conv_code, exp_c);
		chk("level", analog_output_level, lv[21:0]);
		@(posedge clk);
		#1;
		chk("pulse", code_load, 1'b0);
		rd(`DGO_IDX_STATUS, {12'h000, 1'b1, lo, hi, 1'b0});
		rd(`DGO_IDX_DATA, d);
		rd(`DGO_IDX_OFFSET, o);
	endtask : cal

	// ==========================================================
	// clock, timeout, sequence
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			error_cnt++;
			final_report();
		end
	end

	initial
	begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_idx = `DGO_IDX_DATA;
		reg_wdata = 16'h0000;
		lf = 16'h005B;
		tbl = '{48'h8000_8000_0000, 48'hFFFF_0000_0000, 48'hFFFF_FFFF_7FFF,
			48'h0000_8000_8000, 48'h0003_FFFF_FFFF, 48'h1234_C000_0001};
		repeat (10) @(posedge clk);
		#1;
		rst = 1'b0;
		rd(`DGO_IDX_DATA, `DGO_RST_DATA);
		rd(`DGO_IDX_GAIN, `DGO_RST_GAIN);
		rd(`DGO_IDX_OFFSET, `DGO_RST_OFFSET);
		rd(`DGO_IDX_STATUS, 16'h0000);
		for (int k = 0; k < 6; k++)
			cal(tbl[k][47:32], tbl[k][31:16], tbl[k][15:0], k[0]);
		wr(`DGO_IDX_GAIN, 16'h0000);
		wr(`DGO_IDX_OFFSET, 16'h7FFF);
		reg_wr = 1'b0;
		repeat (5) @(posedge clk);
		#1;
		chk("held", conv_code, exp_c);
		wr(`DGO_IDX_STATUS, 16'hFFFF);
		reg_wr = 1'b0;
		rd(`DGO_IDX_STATUS, {12'h000, 1'b1, lo, hi, 1'b0});
		cal(16'h1234, 16'h0000, 16'h7FFF, 1'b0);
		wr(`DGO_IDX_DATA, 16'hFFFF);
		wr(`DGO_IDX_STATUS, 16'h0000);
		wr(`DGO_IDX_DATA, 16'h4000);
		reg_wr = 1'b0;
		chk("restart", code_load, 1'b0);
		chk("keep", conv_code, exp_c);
		repeat (2) @(posedge clk);
		#1;
		exp_c = ecode(16'h4000, 16'h0000, 16'h7FFF, hi, lo);
		chk("restart_load", code_load, 1'b1);
		chk("restart_code", conv_code, exp_c);
		repeat (16)
		begin
			lf = nx(lf);
			rd_d = lf;
			lf = nx(lf);
			rd_g = lf;
			lf = nx(lf);
			cal(rd_d, rd_g, lf, lf[0]);
		end
		rst = 1'b1;
		@(posedge clk);
		#1;
		rst = 1'b0;
		rd(`DGO_IDX_GAIN, `DGO_RST_GAIN);
		chk("code_rst", conv_code, 16'h0000);
		final_report();
	end
endmodule : dgo_calibration_bench
`default_nettype wire

//--- tb/dgo_calibration_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "dgo_params.svh"

// ==========================================================
// port checker
module dgo_calibration_monitor #(
	parameter int RES = 16
) (
	input wire logic                     clk,                // clock
	input wire logic                     rst,                // reset
	input wire logic                     reg_wr,             // write strobe
	input wire logic                     reg_rd,             // read strobe
	input wire dgo_pkg::dgo_reg_idx_t    reg_idx,            // index
	input wire logic [15:0]              reg_rdata,          // read data
	input wire logic                     reg_rvalid,         // read valid
	input wire logic [RES-1:0]           conv_code,          // code
	input wire logic                     code_load,          // load pulse
	input wire logic                     busy,               // busy
	input wire logic [`DGO_FSR_UV_W-1:0] analog_output_level // level
);
	import dgo_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic wd;
	assign wd = reg_wr && (reg_idx == `DGO_IDX_DATA);
	AST_LOAD_LAT: assert property (wd ##1 !wd ##1 !wd |=> code_load)
		else $error("no load three cycles after data write");
	AST_LOAD_CAUSE: assert property (code_load |-> $past(wd, 3) && !$past(wd, 2) && !$past(wd))
		else $error("load without matching data write");
	AST_ONE_PULSE: assert property (code_load |=> !code_load)
		else $error("load pulse too long");
	AST_BUSY: assert property (wd |=> busy [*2])
		else $error("busy missing after data write");
	AST_BUSY_END: assert property (code_load |-> !busy)
		else $error("busy at load");
	AST_CODE_HOLD: assert property (!code_load |-> $stable(conv_code))
		else $error("code moved without load");
	AST_LEVEL: assert property (code_load |->
		analog_output_level == ((64'(conv_code) * 64'(`DGO_FSR_UV)) >> RES))
		else $error("level does not match code");
	AST_LEVEL_HOLD: assert property (!code_load |-> $stable(analog_output_level))
		else $error("level moved without load");
	AST_RVALID: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered");
	AST_RV_CAUSE: assert property (reg_rvalid |-> $past(reg_rd))
		else $error("read valid without read");
	cover property (wd ##1 wd);
	cover property (code_load);
	cover property (reg_rvalid);
	cover property (wd ##2 wd);
endmodule : dgo_calibration_monitor

bind dgo_calibration dgo_calibration_monitor #(.RES(RES)) dgo_calibration_monitor_inst (
	.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_idx(reg_idx),
	.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .conv_code(conv_code),
	.code_load(code_load), .busy(busy), .analog_output_level(analog_output_level));
`default_nettype wire
